// *** epp_regs.svh ***
/*
  register offsets, field positions, reset values and thresholds of the ethernet pcs side port.
  assumes a 32-bit avalon-mm slave with byte addresses.
*/
`ifndef EPP_REGS_SVH
`define EPP_REGS_SVH
`define EPP_OFF_CTRL     6'h00
`define EPP_OFF_STAT     6'h04
`define EPP_OFF_ISTAT    6'h08
`define EPP_OFF_IMASK    6'h0c
`define EPP_OFF_LEVEL    6'h10
`define EPP_CTRL_RST     2'h3
`define EPP_CTRL_TXEN    0
`define EPP_CTRL_RXEN    1
`define EPP_EV_TXOVF     0
`define EPP_EV_RXOVF     1
`define EPP_EV_DECERR    2
`define EPP_EV_TXAFULL   3
`define EPP_ST_EMPTY     3
`define EPP_ST_AEMPTY    2
`define EPP_ST_FULL      1
`define EPP_ST_AFULL     0
`define EPP_THR_DIV      16
`define EPP_THR_HI       15
`define EPP_SYM_HALT     5'h04
`define EPP_SYM_VERR     10'h1e8
`endif

// *** epp_pkg.sv ***
/*
  types shared by the ethernet pcs side port and its line codec.
  assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none
package epp_pkg;
    typedef enum logic {EPP_MII, EPP_GMII} epp_mode_e;
    typedef logic [3:0] epp_fstat_t;
endpackage : epp_pkg
`default_nettype wire

// *** epp_codec.sv ***
/*
  line codec: 4b/5b for the nibble mode, 8b/10b with running disparity for the byte mode.
  assumes the caller strobes enc_stb_i once per data symbol actually sent.
*/
`timescale 1ns/1ps
`default_nettype none
`include "epp_regs.svh"
module epp_codec #(
    parameter epp_pkg::epp_mode_e MODE = epp_pkg::EPP_GMII,
    parameter int                 DW   = (MODE == epp_pkg::EPP_GMII) ? 8 : 4,
    parameter int                 SW   = (MODE == epp_pkg::EPP_GMII) ? 10 : 5
) (
    // clock and reset
    input  wire logic          core_clk_i,
    input  wire logic          rst_i,
    // encoder
    input  wire logic          enc_stb_i,
    input  wire logic [DW-1:0] enc_data_i,
    input  wire logic          enc_err_i,
    output logic      [SW-1:0] enc_sym_o,
    // decoder
    input  wire logic [SW-1:0] dec_sym_i,
    output logic      [DW-1:0] dec_data_o,
    output logic               dec_err_o
);
    localparam logic [31:0][5:0] T6 = {6'h2b, 6'h1e, 6'h2e, 6'h0e, 6'h36, 6'h16, 6'h26, 6'h33,
        6'h3a, 6'h1a, 6'h2a, 6'h0b, 6'h32, 6'h13, 6'h23, 6'h1b, 6'h17, 6'h1c, 6'h2c, 6'h0d,
        6'h34, 6'h15, 6'h25, 6'h39, 6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2d, 6'h1d, 6'h27};
    localparam logic [7:0][3:0] T4 = {4'he, 4'h6, 4'ha, 4'hd, 4'hc, 4'h5, 4'h9, 4'hb};
    localparam logic [15:0][4:0] T5 = {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12,
        5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};

    typedef struct packed {
        logic rd;
    } epp_codec_s;
    epp_codec_s q, d;

    // 8b/10b symbol is {abcdei, fghj} with a in the msb
    always_comb begin
        logic [5:0] c6;
        logic [3:0] c4;
        logic       rd1;
        logic       rd2;
        c6 = '0;
        c4 = '0;
        rd1 = q.rd;
        rd2 = q.rd;
        d = q;
        enc_sym_o = '0;
        dec_data_o = '0;
        dec_err_o = 1'b1;
        if (MODE == epp_pkg::EPP_GMII) begin
            c6 = T6[enc_data_i[4:0]];
            rd1 = q.rd ^ ($countones(c6) != 3);
            c4 = T4[enc_data_i[DW-1:5]];
            if (enc_data_i[DW-1:5] == 3'h7 && ((!rd1 && (enc_data_i[4:0] == 5'd17 ||
                enc_data_i[4:0] == 5'd18 || enc_data_i[4:0] == 5'd20)) || (rd1 &&
                (enc_data_i[4:0] == 5'd11 || enc_data_i[4:0] == 5'd13 || enc_data_i[4:0] == 5'd14)))) begin
                c4 = 4'h7;
            end
            rd2 = rd1 ^ ($countones(c4) != 2);
            // complement the unbalanced codes, and the two balanced special codes, at positive disparity
            if (q.rd && ($countones(c6) != 3 || enc_data_i[4:0] == 5'd7)) begin
                c6 = ~c6;
            end
            if (rd1 && ($countones(c4) != 2 || enc_data_i[DW-1:5] == 3'h3)) begin
                c4 = ~c4;
            end
            enc_sym_o = enc_err_i ? SW'(`EPP_SYM_VERR) : SW'({c6, c4});
            if (enc_stb_i && !enc_err_i) begin
                d.rd = rd2;
            end
            dec_data_o = DW'(dec8(dec_sym_i));
            dec_err_o = dec8(dec_sym_i) > 9'd255;
        end else begin
            enc_sym_o = enc_err_i ? SW'(`EPP_SYM_HALT) : SW'(T5[enc_data_i[3:0]]);
            dec_data_o = DW'(dec5(dec_sym_i));
            dec_err_o = dec5(dec_sym_i) > 5'd15;
        end
    end

    // returns 256 or above when either sub-block, abcdei or fghj, is no data code of either disparity
    function automatic logic [8:0] dec8(input logic [SW-1:0] s);
        logic [4:0] v5;
        logic [2:0] v3;
        logic       h6;
        logic       h4;
        v5 = '0;
        v3 = '0;
        h6 = 1'b0;
        h4 = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (s[SW-1:4] == T6[i] || (($countones(T6[i]) != 3 || i == 7) && s[SW-1:4] == ~T6[i])) begin
                v5 = 5'(i);
                h6 = 1'b1;
            end
        end
        for (int i = 0; i < 8; i++) begin
            if (s[3:0] == T4[i] || (($countones(T4[i]) != 2 || i == 3) && s[3:0] == ~T4[i])) begin
                v3 = 3'(i);
                h4 = 1'b1;
            end
        end
        if (s[3:0] == 4'h7 || s[3:0] == 4'h8) begin
            v3 = 3'h7;
            h4 = 1'b1;
        end
        dec8 = {!(h6 && h4), v3, v5};
    endfunction : dec8

    function automatic logic [4:0] dec5(input logic [SW-1:0] s);
        dec5 = 5'h10;
        for (int i = 0; i < 16; i++) begin
            if (s[4:0] == T5[i]) begin
                dec5 = 5'(i);
            end
        end
    endfunction : dec5

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : epp_codec
`default_nettype wire

// *** epp_port.sv ***
/*
  ethernet pcs side port: mac tx stream -> fifo -> line coder -> link, link -> decoder -> fifo -> mac rx.
  assumes every mac and link pin is asynchronous to core_clk_i and toggles well below its rate;
  registers sit behind a 32-bit avalon-mm slave with waitrequest.
*/
`timescale 1ns/1ps
`default_nettype none
`include "epp_regs.svh"
module epp_port #(
    parameter epp_pkg::epp_mode_e MODE  = epp_pkg::EPP_GMII,
    parameter int                 DEPTH = 32,
    parameter int                 DW    = (MODE == epp_pkg::EPP_GMII) ? 8 : 4,
    parameter int                 SW    = (MODE == epp_pkg::EPP_GMII) ? 10 : 5
) (
    // clock and reset
    input  wire logic          core_clk_i,
    input  wire logic          rst_i,
    // avalon-mm slave
    input  wire logic [5:0]    avs_address_i,
    input  wire logic          avs_read_i,
    input  wire logic          avs_write_i,
    input  wire logic [31:0]   avs_writedata_i,
    input  wire logic [3:0]    avs_byteenable_i,
    output logic      [31:0]   avs_readdata_o,
    output logic               avs_waitrequest_o,
    output logic               irq_o,
    // mac transmit side
    input  wire logic          mac_txclk_i,
    input  wire logic          mac_tx_rst_n_i,
    input  wire logic          mac_txen_i,
    input  wire logic          mac_txer_i,
    input  wire logic [DW-1:0] mac_txd_i,
    output logic      [3:0]    tx_fifo_status_o,
    // mac receive side
    input  wire logic          mac_rxclk_i,
    input  wire logic          mac_rx_rst_n_i,
    output logic               mac_rxdv_o,
    output logic               mac_rxer_o,
    output logic      [DW-1:0] mac_rxd_o,
    output logic      [3:0]    rx_fifo_status_o,
    // link
    input  wire logic          link_clk_i,
    output logic               link_tx_dv_o,
    output logic      [SW-1:0] link_tx_sym_o,
    input  wire logic          link_rx_dv_i,
    input  wire logic [SW-1:0] link_rx_sym_i
);
    localparam int AW   = $clog2(DEPTH);
    localparam int TXC  = 0;
    localparam int TXEN = 1;
    localparam int TXER = 2;
    localparam int TXD  = 3;
    localparam int TRST = 3 + DW;
    localparam int RXC  = 4 + DW;
    localparam int RRST = 5 + DW;
    localparam int LCK  = 6 + DW;
    localparam int LDV  = 7 + DW;
    localparam int LSYM = 8 + DW;
    localparam int PW   = 8 + DW + SW;
    localparam logic [AW:0] LO_THR = (AW + 1)'(DEPTH / `EPP_THR_DIV);
    localparam logic [AW:0] HI_THR = (AW + 1)'(DEPTH / `EPP_THR_DIV * `EPP_THR_HI);

    // the thresholds are exact only on whole sixteenths
    if (DEPTH < 16 || DEPTH % 16 != 0 || DEPTH != (1 << AW)) begin : g_bad_depth
        $error("epp_port: DEPTH must be a power of two of at least 16");
    end
    // port widths follow the mode, so the byte-wide port only exists in the byte mode
    if (DW != ((MODE == epp_pkg::EPP_GMII) ? 8 : 4) || SW != DW + DW / 4) begin : g_bad_width
        $error("epp_port: DW and SW must follow MODE");
    end

    typedef struct packed {
        logic [PW-1:0]              s1;
        logic [PW-1:0]              s2;
        logic [PW-1:0]              s3;
        logic [DEPTH-1:0][DW:0]     txm;
        logic [AW-1:0]              twp;
        logic [AW-1:0]              trp;
        logic [AW:0]                tcnt;
        logic [DEPTH-1:0][DW:0]     rxm;
        logic [AW-1:0]              rwp;
        logic [AW-1:0]              rrp;
        logic [AW:0]                rcnt;
        epp_pkg::epp_fstat_t        tst_a;
        epp_pkg::epp_fstat_t        tst_b;
        epp_pkg::epp_fstat_t        tst;
        epp_pkg::epp_fstat_t        rst;
        logic                       ldv;
        logic [SW-1:0]              lsym;
        logic                       rxdv;
        logic                       rxer;
        logic [DW-1:0]              rxd;
        logic [1:0]                 ctrl;
        logic [3:0]                 ist;
        logic [3:0]                 imsk;
        logic                       irq;
        logic                       wait_r;
        logic [31:0]                rdata;
    } epp_port_s;
    epp_port_s q, d;

    logic [SW-1:0] enc_sym;
    logic [DW-1:0] dec_data;
    logic          dec_err;
    logic          tx_pop;

    function automatic epp_pkg::epp_fstat_t fstat(input logic [AW:0] n);
        fstat = '0;
        fstat[`EPP_ST_EMPTY] = (n == '0);
        fstat[`EPP_ST_AEMPTY] = (n <= LO_THR);
        fstat[`EPP_ST_FULL] = (n == (AW + 1)'(DEPTH));
        fstat[`EPP_ST_AFULL] = (n >= HI_THR);
    endfunction : fstat

    // entries hold raw data and the error flag only; frame fields are never looked at
    epp_codec #(
        .MODE (MODE),
        .DW   (DW),
        .SW   (SW)
    ) u_codec (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .enc_stb_i  (tx_pop),
        .enc_data_i (q.txm[q.trp][DW-1:0]),
        .enc_err_i  (q.txm[q.trp][DW]),
        .enc_sym_o  (enc_sym),
        .dec_sym_i  (q.s2[LSYM +: SW]),
        .dec_data_o (dec_data),
        .dec_err_o  (dec_err)
    );

    assign tx_pop = q.s2[LCK] && !q.s3[LCK] && q.tcnt != '0;

    always_comb begin
        logic       tx_rst;
        logic       rx_rst;
        logic       tx_push;
        logic       rx_push;
        logic       rx_pop;
        logic       tx_ok;
        logic       rx_ok;
        logic [3:0] ev;
        logic [3:0] clr;
        logic       acc;
        d = q;
        ev = '0;
        clr = '0;
        {tx_rst, rx_rst, tx_push, rx_push, rx_pop, tx_ok, rx_ok, acc} = '0;
        d.s1 = {link_rx_sym_i, link_rx_dv_i, link_clk_i, mac_rx_rst_n_i, mac_rxclk_i,
                mac_tx_rst_n_i, mac_txd_i, mac_txer_i, mac_txen_i, mac_txclk_i};
        d.s2 = q.s1;
        d.s3 = q.s2;
        tx_rst = !q.s2[TRST];
        rx_rst = !q.s2[RRST];

        // transmit fifo, written on the mac clock rising edge
        tx_push = q.s2[TXC] && !q.s3[TXC] && q.s2[TXEN] && q.ctrl[`EPP_CTRL_TXEN] && !tx_rst;
        tx_ok = tx_push && q.tcnt != (AW + 1)'(DEPTH);
        ev[`EPP_EV_TXOVF] = tx_push && !tx_ok;
        if (tx_ok) begin
            d.txm[q.twp] = {q.s2[TXER], q.s2[TXD +: DW]};
            d.twp = q.twp + 1'b1;
        end
        d.ldv = tx_pop;
        d.lsym = tx_pop ? enc_sym : '0;
        if (tx_pop) begin
            d.trp = q.trp + 1'b1;
        end
        d.tcnt = q.tcnt + (AW + 1)'(tx_ok) - (AW + 1)'(tx_pop);
        if (tx_rst) begin
            d.twp = '0;
            d.trp = '0;
            d.tcnt = '0;
        end
        // two stages stand for the crossing; a writer must allow for the lag
        d.tst_a = fstat(q.tcnt);
        d.tst_b = q.tst_a;
        d.tst = q.tst_b;
        ev[`EPP_EV_TXAFULL] = q.tst_b[`EPP_ST_AFULL] && !q.tst[`EPP_ST_AFULL];

        // receive fifo, filled at the link clock rising edge
        rx_push = q.s2[LCK] && !q.s3[LCK] && q.s2[LDV] && q.ctrl[`EPP_CTRL_RXEN] && !rx_rst;
        rx_ok = rx_push && q.rcnt != (AW + 1)'(DEPTH);
        ev[`EPP_EV_RXOVF] = rx_push && !rx_ok;
        ev[`EPP_EV_DECERR] = rx_push && dec_err;
        if (rx_ok) begin
            d.rxm[q.rwp] = {dec_err, dec_data};
            d.rwp = q.rwp + 1'b1;
        end
        // drained on the mac clock falling edge so data are stable at its rising edge
        rx_pop = !q.s2[RXC] && q.s3[RXC];
        if (rx_pop) begin
            d.rxdv = q.rcnt != '0;
            d.rxer = q.rcnt != '0 && q.rxm[q.rrp][DW];
            d.rxd = q.rcnt != '0 ? q.rxm[q.rrp][DW-1:0] : '0;
        end
        rx_ok = rx_pop && q.rcnt != '0;
        if (rx_ok) begin
            d.rrp = q.rrp + 1'b1;
        end
        d.rcnt = q.rcnt + (AW + 1)'(rx_push && q.rcnt != (AW + 1)'(DEPTH)) - (AW + 1)'(rx_ok);
        if (rx_rst) begin
            d.rwp = '0;
            d.rrp = '0;
            d.rcnt = '0;
            d.rxdv = 1'b0;
            d.rxer = 1'b0;
            d.rxd = '0;
        end
        // updated only when the mac clock falls or during rx_rst, so the mac never samples a changing level
        if (rx_pop || rx_rst) begin
            d.rst = fstat(d.rcnt);
        end

        // avalon slave: one wait cycle, then the answer stands while waitrequest is low
        acc = (avs_read_i || avs_write_i) && !q.wait_r;
        d.wait_r = !((avs_read_i || avs_write_i) && q.wait_r);
        if (avs_read_i && q.wait_r) begin
            unique case (avs_address_i)
                `EPP_OFF_CTRL:  d.rdata = {30'h0, q.ctrl};
                `EPP_OFF_STAT:  d.rdata = {23'h0, MODE == epp_pkg::EPP_GMII, q.rst, q.tst};
                `EPP_OFF_ISTAT: d.rdata = {28'h0, q.ist};
                `EPP_OFF_IMASK: d.rdata = {28'h0, q.imsk};
                `EPP_OFF_LEVEL: d.rdata = {16'h0, 8'(q.rcnt), 8'(q.tcnt)};
                default:        d.rdata = 32'h0;
            endcase
        end
        if (acc && avs_write_i && avs_byteenable_i[0]) begin
            unique case (avs_address_i)
                `EPP_OFF_CTRL:  d.ctrl = avs_writedata_i[1:0];
                `EPP_OFF_ISTAT: clr = avs_writedata_i[3:0];
                `EPP_OFF_IMASK: d.imsk = avs_writedata_i[3:0];
                default:        d.ctrl = q.ctrl;
            endcase
        end
        // a new event beats a clear in the same cycle
        d.ist = (q.ist & ~clr) | ev;
        d.irq = |(d.ist & d.imsk);
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.ctrl <= `EPP_CTRL_RST;
            q.wait_r <= 1'b1;
            q.tst_a <= 4'hc;
            q.tst_b <= 4'hc;
            q.tst <= 4'hc;
            q.rst <= 4'hc;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata_o = q.rdata;
    assign avs_waitrequest_o = q.wait_r;
    assign irq_o = q.irq;
    assign tx_fifo_status_o = q.tst;
    assign rx_fifo_status_o = q.rst;
    assign mac_rxdv_o = q.rxdv;
    assign mac_rxer_o = q.rxer;
    assign mac_rxd_o = q.rxd;
    assign link_tx_dv_o = q.ldv;
    assign link_tx_sym_o = q.lsym;
endmodule : epp_port
`default_nettype wire

// *** epp_port_asserts.sv ***
/*
  concurrent checks on the ports of epp_port.
  assumes mac clocks with half periods of at least six core cycles and a link clock of eight-cycle period.
*/
`timescale 1ns/1ps
`default_nettype none
module epp_port_asserts #(
    parameter int SW = 10
) (
    // clock and reset
    input wire logic          core_clk_i,
    input wire logic          rst_i,
    // watched ports
    input wire logic          mac_rxclk_i,
    input wire logic          mac_rx_rst_n_i,
    input wire logic          mac_rxdv_o,
    input wire logic [3:0]    tx_fifo_status_o,
    input wire logic [3:0]    rx_fifo_status_o,
    input wire logic          link_tx_dv_o,
    input wire logic [SW-1:0] link_tx_sym_o,
    input wire logic          avs_waitrequest_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    a_tx_empty_bits: assert property (tx_fifo_status_o[3] |-> tx_fifo_status_o[2:0] == 3'h4)
        else $error("tx empty without almost empty");
    a_tx_full_bits: assert property (tx_fifo_status_o[1] |-> tx_fifo_status_o == 4'h3)
        else $error("tx full without almost full");
    a_rx_empty_bits: assert property (rx_fifo_status_o[3] |-> rx_fifo_status_o[2:0] == 3'h4)
        else $error("rx empty without almost empty");
    a_rx_full_bits: assert property (rx_fifo_status_o[1] |-> rx_fifo_status_o == 4'h3)
        else $error("rx full without almost full");
    // rx outputs belong to the mac rx domain, so they may only move while that clock is low
    a_rx_stat_dom: assert property (disable iff (rst_i || !mac_rx_rst_n_i)
        $changed(rx_fifo_status_o) |-> !mac_rxclk_i) else $error("rx status moved off the rx clock");
    a_rxdv_dom: assert property (disable iff (rst_i || !mac_rx_rst_n_i)
        ($rose(mac_rxdv_o) || $fell(mac_rxdv_o)) |-> !mac_rxclk_i) else $error("rx valid moved off the rx clock");
    a_link_one_sym: assert property (link_tx_dv_o |=> !link_tx_dv_o [*4])
        else $error("more than one symbol per link clock");
    a_link_idle_sym: assert property (!link_tx_dv_o |-> link_tx_sym_o == '0)
        else $error("symbol driven without valid");
    a_bus_ack_once: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
endmodule : epp_port_asserts

bind epp_port epp_port_asserts #(.SW(SW)) u_asserts (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .mac_rxclk_i(mac_rxclk_i), .mac_rx_rst_n_i(mac_rx_rst_n_i),
    .mac_rxdv_o(mac_rxdv_o), .tx_fifo_status_o(tx_fifo_status_o), .rx_fifo_status_o(rx_fifo_status_o),
    .link_tx_dv_o(link_tx_dv_o), .link_tx_sym_o(link_tx_sym_o), .avs_waitrequest_o(avs_waitrequest_o)
);
`default_nettype wire

// *** epp_mac_model.sv ***
/*
  mac partner: makes the mac clocks from the core clock, sends entries, collects received entries.
  assumes core_clk_i is the bench clock; HALF core cycles make half a mac clock period.
*/
`timescale 1ns/1ps
`default_nettype none
module epp_mac_model #(
    parameter int DW   = 8,
    parameter int HALF = 6
) (
    // bench side
    input  wire logic          core_clk_i,
    input  wire logic          rx_run_i,
    // mac transmit pins
    output logic               txclk_o,
    output logic               txen_o,
    output logic               txer_o,
    output logic      [DW-1:0] txd_o,
    // mac receive pins
    output logic               rxclk_o,
    input  wire logic          rxdv_i,
    input  wire logic          rxer_i,
    input  wire logic [DW-1:0] rxd_i
);
    // real mac clocks run at 125 mhz; scaled so the core clock can oversample them
    int          ph = 0;
    logic [DW:0] rx_q[$];
    initial begin
        txclk_o = 1'b0;
        rxclk_o = 1'b0;
        txen_o  = 1'b0;
        txer_o  = 1'b0;
        txd_o   = '0;
    end
    always @(posedge core_clk_i) begin
        ph <= (ph == HALF - 1) ? 0 : ph + 1;
        if (ph == HALF - 1) begin
            txclk_o <= ~txclk_o;
            if (rx_run_i) begin
                rxclk_o <= ~rxclk_o;
                if (!rxclk_o && rxdv_i) begin
                    rx_q.push_back({rxer_i, rxd_i});
                end
            end
        end
    end
    // frame bytes are opaque here; the caller sends them without pacing against the fill status
    task automatic send(input logic [DW-1:0] d, input logic er);
        @(posedge core_clk_i iff (ph == HALF - 1 && txclk_o));
        txen_o <= 1'b1;
        txer_o <= er;
        txd_o  <= d;
    endtask : send
    // idle gap: enable low and data no longer held
    task automatic gap(input int n);
        repeat (n) begin
            @(posedge core_clk_i iff (ph == HALF - 1 && txclk_o));
            txen_o <= 1'b0;
            txd_o  <= ~txd_o;
        end
    endtask : gap
endmodule : epp_mac_model
`default_nettype wire

// *** tb_ethernet_pcs_side_port.sv ***
/*
  bench for epp_port in byte mode: registers, tx fill, link loopback, rx drain, error symbols, tx reset.
  assumes epp_mac_model as the mac; the bench echoes link symbols back as the far link end.
*/
`timescale 1ns/1ps
`default_nettype none
`include "epp_regs.svh"
module tb_ethernet_pcs_side_port;
    localparam int DEPTH = 32;
    logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, inj = 1'b0, lb_dv = 1'b0;
    logic        link_clk = 1'b0, link_run = 1'b0, rx_run = 1'b0, tx_rst_n = 1'b0, rx_rst_n = 1'b0;
    logic        wreq, irq, txclk, txen, txer, rxclk, rxdv, rxer, ldv, got_sym = 1'b0, got_rx = 1'b0;
    logic [5:0]  adr = '0;
    logic [3:0]  be = 4'hf;
    logic [31:0] wdat = '0, rdat, rv;
    logic [7:0]  txd, rxd;
    logic [3:0]  txst, rxst, first_rxst;
    logic [9:0]  lsym, lb_sym = '0, first_sym, last_sym;
    int          lb_age = 13, error_cnt = 0, tests_run = 0;

    always #50 clk = ~clk;
    // link clock unrelated in phase to the core clock, still while the link is idle
    initial begin
        #137;
        forever begin
            #400;
            if (link_run) begin
                link_clk = ~link_clk;
            end
        end
    end

    epp_port #(.DEPTH(DEPTH)) dut (
        .core_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .irq_o(irq), .mac_txclk_i(txclk), .mac_tx_rst_n_i(tx_rst_n), .mac_txen_i(txen), .mac_txer_i(txer),
        .mac_txd_i(txd), .tx_fifo_status_o(txst), .mac_rxclk_i(rxclk), .mac_rx_rst_n_i(rx_rst_n),
        .mac_rxdv_o(rxdv), .mac_rxer_o(rxer), .mac_rxd_o(rxd), .rx_fifo_status_o(rxst), .link_clk_i(link_clk),
        .link_tx_dv_o(ldv), .link_tx_sym_o(lsym), .link_rx_dv_i(lb_dv | inj),
        .link_rx_sym_i(inj ? 10'h000 : lb_sym)
    );
    epp_mac_model #(.DW(8), .HALF(6)) mac (
        .core_clk_i(clk), .rx_run_i(rx_run), .txclk_o(txclk), .txen_o(txen), .txer_o(txer), .txd_o(txd),
        .rxclk_o(rxclk), .rxdv_i(rxdv), .rxer_i(rxer), .rxd_i(rxd)
    );

    // echo each symbol until the next link rise has taken it, then release the line
    always @(posedge clk) begin
        if (ldv) begin
            lb_dv    <= 1'b1;
            lb_sym   <= lsym;
            lb_age   <= 0;
            last_sym <= lsym;
            got_sym  <= 1'b1;
            if (!got_sym) begin
                first_sym <= lsym;
            end
        end else if (lb_age < 13) begin
            lb_age <= lb_age + 1;
            if (lb_age == 12) begin
                lb_dv  <= 1'b0;
                lb_sym <= ~lb_sym;
            end
        end
        if (rxdv && !got_rx) begin
            first_rxst <= rxst;
            got_rx     <= 1'b1;
        end
    end

    function automatic logic [3:0] fexp(input int n);
        return {n == 0, n <= DEPTH / 16, n == DEPTH, n >= 15 * DEPTH / 16};
    endfunction : fexp
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic av(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        adr  <= a;
        wdat <= d;
        rd   <= !w;
        wr   <= w;
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        rv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : av
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask : tend
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        test_done();
    end

    initial begin
        cyc(8);
        rst      <= 1'b0;
        tx_rst_n <= 1'b1;
        rx_rst_n <= 1'b1;
        cyc(4);
        chk(32'(txst), 32'hc, "tx status idle");
        chk(32'(rxst), 32'hc, "rx status idle");
        av(1'b0, `EPP_OFF_STAT, 32'h0);
        chk(rv, 32'h1cc, "stat word");
        av(1'b0, 6'h3c, 32'h0);
        chk(rv, 32'h0, "unmapped read");
        be <= 4'he;
        av(1'b1, `EPP_OFF_CTRL, 32'h0);
        be <= 4'hf;
        av(1'b0, `EPP_OFF_CTRL, 32'h0);
        chk(rv, 32'h3, "write without lane 0 ignored");
        tend("reset");
        // link held still so the tx fifo fills past full
        for (int i = 0; i <= DEPTH; i++) begin
            mac.send(8'(i), 1'b0);
            cyc(6);
            chk(32'(txst), 32'(fexp(i)), "tx fill status");
        end
        mac.gap(12);
        chk(32'(txst), 32'h3, "tx full");
        av(1'b0, `EPP_OFF_ISTAT, 32'h0);
        chk(rv, 32'h9, "overflow and almost full events");
        chk(32'(irq), 32'h0, "irq masked");
        av(1'b1, `EPP_OFF_IMASK, 32'h1);
        cyc(2);
        chk(32'(irq), 32'h1, "irq unmasked");
        av(1'b1, `EPP_OFF_ISTAT, 32'h9);
        cyc(2);
        chk(32'(irq), 32'h0, "irq cleared");
        tend("fill");
        link_run <= 1'b1;
        for (int k = 0; k < 100 && txst !== 4'hc; k++) cyc(8);
        cyc(40);
        av(1'b0, `EPP_OFF_LEVEL, 32'h0);
        chk(rv, 32'h2000, "rx holds the frame");
        chk(32'(first_sym), 32'h274, "first coded byte");
        rx_run <= 1'b1;
        for (int k = 0; k < 1000 && mac.rx_q.size() < DEPTH; k++) cyc(1);
        for (int i = 0; i < DEPTH; i++) begin
            chk(32'(mac.rx_q[i]), 32'(i), "rx byte");
        end
        chk(32'(first_rxst & 4'hd), 32'h1, "rx almost full");
        cyc(30);
        chk(32'(rxst), 32'hc, "rx drained");
        tend("loopback");
        for (int i = 0; i < 8; i++) mac.send(8'h40 + 8'(i), i == 7);
        mac.gap(12);
        cyc(40);
        chk(32'(last_sym), 32'(`EPP_SYM_VERR), "error symbol");
        av(1'b1, `EPP_OFF_ISTAT, 32'hf);
        mac.rx_q.delete();
        tend("txer");
        inj <= 1'b1;
        cyc(20);
        inj <= 1'b0;
        cyc(60);
        av(1'b0, `EPP_OFF_ISTAT, 32'h0);
        chk(rv & 32'h4, 32'h4, "decode error event");
        chk(32'(mac.rx_q[0][8]), 32'h1, "rx error flag");
        av(1'b1, `EPP_OFF_IMASK, 32'h4);
        cyc(2);
        chk(32'(irq), 32'h1, "decode irq");
        av(1'b1, `EPP_OFF_ISTAT, 32'h4);
        cyc(2);
        chk(32'(irq), 32'h0, "decode irq cleared");
        tend("decode");
        link_run <= 1'b0;
        cyc(20);
        av(1'b1, `EPP_OFF_CTRL, 32'h2);
        for (int i = 0; i < 8; i++) mac.send(8'h80 + 8'(i), 1'b0);
        mac.gap(12);
        av(1'b0, `EPP_OFF_LEVEL, 32'h0);
        chk(rv, 32'h0, "tx disabled takes nothing");
        av(1'b1, `EPP_OFF_CTRL, 32'h3);
        for (int i = 0; i < 8; i++) mac.send(8'(i), 1'b0);
        mac.gap(12);
        chk(32'(txst), 32'h0, "tx between thresholds");
        tx_rst_n <= 1'b0;
        rx_rst_n <= 1'b0;
        cyc(8);
        chk(32'(txst), 32'hc, "tx reset empties");
        chk(32'(rxst), 32'hc, "rx reset empties");
        chk(32'(rxdv), 32'h0, "rx valid low in reset");
        tx_rst_n <= 1'b1;
        rx_rst_n <= 1'b1;
        tend("txreset");
        test_done();
    end
endmodule : tb_ethernet_pcs_side_port
`default_nettype wire
